/* inc/odc_pkg.sv */
// constants, types and reset values of the display command decoder
package odc_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int INIT_BUSY_NS = 2000;
  localparam int INIT_BUSY_CYC =
    (INIT_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CNT_W = 8;

  // ==========================================================
  // field positions
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_OFF_BIT = 6;
  localparam int SCTL_CO_BIT = 7;
  localparam int SCTL_DC_BIT = 6;

  // ==========================================================
  // command codes, ? marks argument bits
  localparam logic [7:0] CMD_COL_LO = 8'b0000_????;
  localparam logic [7:0] CMD_COL_HI = 8'b0001_????;
  localparam logic [7:0] CMD_PUMP_V = 8'b0011_00??;
  localparam logic [7:0] CMD_START = 8'b01??_????;
  localparam logic [7:0] CMD_CONTRAST = 8'h81;
  localparam logic [7:0] CMD_SEG = 8'b1010_000?;
  localparam logic [7:0] CMD_ALL_ON = 8'b1010_010?;
  localparam logic [7:0] CMD_INVERSE = 8'b1010_011?;
  localparam logic [7:0] CMD_MUX = 8'hA8;
  localparam logic [7:0] CMD_PUMP_CTL = 8'hAD;
  localparam logic [7:0] CMD_DISP = 8'b1010_111?;
  localparam logic [7:0] CMD_PAGE = 8'b1011_????;
  localparam logic [7:0] CMD_SCAN = 8'b1100_????;
  localparam logic [7:0] CMD_OFFSET = 8'hD3;
  localparam logic [7:0] CMD_CLOCK = 8'hD5;
  localparam logic [7:0] CMD_PERIOD = 8'hD9;
  localparam logic [7:0] CMD_PADS = 8'hDA;
  localparam logic [7:0] CMD_DESEL = 8'hDB;
  localparam logic [7:0] CMD_RMW = 8'hE0;
  localparam logic [7:0] CMD_END = 8'hEE;
  localparam int SCAN_BIT = 3;
  localparam int PUMP_EN_BIT = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_COL = 8'h00;
  localparam logic [3:0] RST_PAGE = 4'h0;
  localparam logic [1:0] RST_PUMP_V = 2'h2;
  localparam logic [5:0] RST_START = 6'h34;
  localparam logic [7:0] RST_CONTRAST = 8'h80;
  localparam logic [5:0] RST_MUX = 6'h3F;
  localparam logic RST_PUMP_EN = 1'b1;
  localparam logic [5:0] RST_OFFSET = 6'h00;
  localparam logic [7:0] RST_CLOCK = 8'h50;
  localparam logic [7:0] RST_PERIOD = 8'h22;
  localparam logic [7:0] RST_PADS = 8'h12;
  localparam logic [7:0] RST_DESEL = 8'h35;

  // ==========================================================
  // types
  typedef struct packed {
    logic wr;
    logic rd;
    logic cmd_data_select;
    logic frame;
    logic [7:0] din;
  } odc_pin_type;

  typedef struct packed {
    logic [1:0] pump_volt;
    logic [5:0] start_line;
    logic [7:0] contrast;
    logic seg_mirror;
    logic all_on;
    logic inverse;
    logic [5:0] mux_ratio;
    logic pump_en;
    logic disp_on;
    logic scan_rev;
    logic [5:0] row_offset_value;
    logic [7:0] osc_div;
    logic [7:0] charge_period;
    logic [7:0] pad_cfg;
    logic [7:0] deselect_level;
  } odc_cfg_type;

  localparam odc_cfg_type RST_CFG = '{
    pump_volt: RST_PUMP_V, start_line: RST_START,
    contrast: RST_CONTRAST, seg_mirror: 1'b0, all_on: 1'b0,
    inverse: 1'b0, mux_ratio: RST_MUX, pump_en: RST_PUMP_EN,
    disp_on: 1'b0, scan_rev: 1'b0, row_offset_value: RST_OFFSET,
    osc_div: RST_CLOCK, charge_period: RST_PERIOD,
    pad_cfg: RST_PADS, deselect_level: RST_DESEL};

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CONTRAST = 4'h1,
    ST_MUX = 4'h2,
    ST_PUMP = 4'h3,
    ST_OFFSET = 4'h4,
    ST_CLOCK = 4'h5,
    ST_PERIOD = 4'h6,
    ST_PADS = 4'h7,
    ST_DESEL = 4'h8
  } odc_state_type;

endpackage : odc_pkg

/* core/odc_decoder.sv */
// display command decoder with its write buffer
`timescale 1ns/100ps

// ============================================================
// write buffer
module odc_fifo
  import odc_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_chk
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = ce & in_valid & in_ready;
  assign pop = ce & out_valid & out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wp_q] <= in_data;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : odc_fifo

// ============================================================
// decoder
// Behaviour
// - status read gives busy in bit 7, display-off in bit 6, low bits zero.
// - every write arriving while busy is dropped.
// - display-off status bit is the inverse of the panel-on setting.
// - data read returns the RAM byte at page/column, then column plus one.
// - first data read after a column change returns stale data.
// - data reads over the serial framing return zero and change nothing.
// - commands 0x0-/0x1- load low and high column nibbles; column resets to 0.
// - command 001100xx stores the pump voltage code, reset code 2.
// - command 01xxxxxx stores the start line, reset 34 hex.
// - contrast command stores its second byte, reset 80 hex.
// - command 1010000x selects normal or mirrored column order.
// - 1010010x forces all pixels on; 1010011x inverts pixels; both reset 0.
// - multiplex command stores a 6-bit ratio, reset 3F (64 rows).
// - pump control command stores its enable bit, reset enabled.
// - 1010111x switches the panel on or off; off after reset.
// - command 1011xxxx loads the page address, reset zero.
// - command 1100Dxxx picks the row scan direction, reset forward.
// - offset command stores a 6-bit row offset, reset zero.
// - clock command stores oscillator and divide nibbles.
// - period command stores discharge and precharge nibbles.
// - in read-modify-write reads keep the column; end restores it.
// - data write stores at page/column, then column plus one.
module odc_decoder
  import odc_pkg::*;
#(
  parameter int COLS = 132,
  parameter int PAGES = 8,
  parameter int FIFO_DEPTH = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // host pins, asynchronous to clk
  input wire odc_pin_type host_pins,
  input wire logic serial_mode,
  output logic [7:0] host_dout,
  // status and settings
  output logic busy,
  output logic wr_ready,
  output odc_cfg_type cfg
);
  if (COLS < 1 || COLS > 256 || PAGES < 1 || PAGES > 16)
  begin : g_chk
    $error("column or page count out of range");
  end

  localparam int RAMW = PAGES * COLS;

  function automatic logic in_ram(input logic [3:0] pg,
                                  input logic [7:0] cl);
    in_ram = (int'(pg) < PAGES) && (int'(cl) < COLS);
  endfunction : in_ram

  function automatic int ram_idx(input logic [3:0] pg,
                                 input logic [7:0] cl);
    ram_idx = int'(pg) * COLS + int'(cl);
  endfunction : ram_idx

  // ==========================================================
  // pin synchronisers
  odc_pin_type s1_q;
  odc_pin_type s2_q;
  odc_pin_type s3_q;
  logic wr_evt;
  logic rd_evt;
  logic frame_evt;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else if (ce)
    begin
      s1_q <= host_pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // edges are taken from the second and third stage only
  assign wr_evt = ce & s2_q.wr & ~s3_q.wr;
  assign rd_evt = ce & s2_q.rd & ~s3_q.rd;
  assign frame_evt = ce & s2_q.frame & ~s3_q.frame;

  // ==========================================================
  // busy after reset
  logic [INIT_CNT_W-1:0] init_q;
  logic init_busy;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      init_q <= INIT_CNT_W'(INIT_BUSY_CYC);
    else if (ce && init_q != '0)
      init_q <= init_q - 1'b1;
  end

  assign init_busy = (init_q != '0);

  // ==========================================================
  // serial framing
  logic expect_ctl_q;
  logic co_q;
  logic sdc_q;
  logic dc_eff;
  logic fifo_in_ready;
  logic push_valid;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      expect_ctl_q <= 1'b1;
      co_q <= 1'b0;
      sdc_q <= 1'b0;
    end
    else if (frame_evt)
      expect_ctl_q <= 1'b1;
    else if (wr_evt & serial_mode & ~busy)
    begin
      if (expect_ctl_q)
      begin
        sdc_q <= s2_q.din[SCTL_DC_BIT];
        co_q <= s2_q.din[SCTL_CO_BIT];
        expect_ctl_q <= 1'b0;
      end
      else if (co_q)
        expect_ctl_q <= 1'b1;
    end
  end

  assign dc_eff = serial_mode ? sdc_q : s2_q.cmd_data_select;
  assign busy = init_busy | ~fifo_in_ready;
  assign wr_ready = ~busy;
  // busy writes are dropped, not held back
  assign push_valid = wr_evt & ~busy & ~(serial_mode & expect_ctl_q);

  // ==========================================================
  // write buffer; reads stall the drain so the column has one owner
  logic pop_valid;
  logic pop_ready;
  logic [8:0] pop_word;
  logic pop;
  logic cmd_pop;
  logic dat_pop;
  logic [7:0] pb;
  odc_state_type st_q;

  odc_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data({dc_eff, s2_q.din}),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_word)
  );

  assign pop_ready = ~rd_evt;
  assign pop = ce & pop_valid & pop_ready;
  assign pb = pop_word[7:0];
  assign cmd_pop = pop & ~pop_word[8] & (st_q == ST_IDLE);
  assign dat_pop = pop & pop_word[8];

  // ==========================================================
  // settings and parameter bytes
  odc_cfg_type cfg_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_q <= RST_CFG;
      st_q <= ST_IDLE;
    end
    else if (pop & ~pop_word[8] & (st_q != ST_IDLE))
    begin
      st_q <= ST_IDLE;
      unique case (st_q)
        ST_CONTRAST: cfg_q.contrast <= pb;
        ST_MUX: cfg_q.mux_ratio <= pb[5:0];
        ST_PUMP: cfg_q.pump_en <= pb[PUMP_EN_BIT];
        ST_OFFSET: cfg_q.row_offset_value <= pb[5:0];
        ST_CLOCK: cfg_q.osc_div <= pb;
        ST_PERIOD: cfg_q.charge_period <= pb;
        ST_PADS: cfg_q.pad_cfg <= pb;
        ST_DESEL: cfg_q.deselect_level <= pb;
        default: st_q <= ST_IDLE;
      endcase
    end
    else if (cmd_pop)
    begin
      casez (pb)
        CMD_PUMP_V: cfg_q.pump_volt <= pb[1:0];
        CMD_START: cfg_q.start_line <= pb[5:0];
        CMD_CONTRAST: st_q <= ST_CONTRAST;
        CMD_SEG: cfg_q.seg_mirror <= pb[0];
        CMD_ALL_ON: cfg_q.all_on <= pb[0];
        CMD_INVERSE: cfg_q.inverse <= pb[0];
        CMD_MUX: st_q <= ST_MUX;
        CMD_PUMP_CTL: st_q <= ST_PUMP;
        CMD_DISP: cfg_q.disp_on <= pb[0];
        CMD_SCAN: cfg_q.scan_rev <= pb[SCAN_BIT];
        CMD_OFFSET: st_q <= ST_OFFSET;
        CMD_CLOCK: st_q <= ST_CLOCK;
        CMD_PERIOD: st_q <= ST_PERIOD;
        CMD_PADS: st_q <= ST_PADS;
        CMD_DESEL: st_q <= ST_DESEL;
        // unlisted codes leave every setting alone
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign cfg = cfg_q;

  // ==========================================================
  // page, column and read-modify-write
  logic [7:0] col_q;
  logic [3:0] page_q;
  logic rmw_q;
  logic [7:0] rmw_col_q;
  logic ram_rd;

  assign ram_rd = rd_evt & dc_eff & ~serial_mode;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      col_q <= RST_COL;
      page_q <= RST_PAGE;
      rmw_q <= 1'b0;
      rmw_col_q <= RST_COL;
    end
    else if (ram_rd)
    begin
      if (!rmw_q)
        col_q <= col_q + 1'b1;
    end
    else if (dat_pop)
      col_q <= col_q + 1'b1;
    else if (cmd_pop)
    begin
      casez (pb)
        CMD_COL_LO: col_q[3:0] <= pb[3:0];
        CMD_COL_HI: col_q[7:4] <= pb[3:0];
        CMD_PAGE: page_q <= pb[3:0];
        CMD_RMW:
        begin
          rmw_q <= 1'b1;
          rmw_col_q <= col_q;
        end
        CMD_END:
        begin
          if (rmw_q)
            col_q <= rmw_col_q;
          rmw_q <= 1'b0;
        end
        default: rmw_q <= rmw_q;
      endcase
    end
  end

  // ==========================================================
  // display RAM; out-of-range addresses are not stored
  logic [7:0] ram_q [RAMW];

  always_ff @(posedge clk)
  begin
    if (dat_pop && in_ram(page_q, col_q))
      ram_q[ram_idx(page_q, col_q)] <= pb;
  end

  // ==========================================================
  // read path; the latch makes the first read after an address
  // change return whatever was fetched before it
  logic [7:0] rd_latch_q;
  logic [7:0] dout_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_latch_q <= 8'h00;
      dout_q <= 8'h00;
    end
    else if (rd_evt)
    begin
      if (!dc_eff)
      begin
        dout_q <= 8'h00;
        dout_q[STAT_BUSY_BIT] <= busy;
        dout_q[STAT_OFF_BIT] <= ~cfg_q.disp_on;
      end
      else if (serial_mode)
        dout_q <= 8'h00;
      else
      begin
        dout_q <= rd_latch_q;
        rd_latch_q <= in_ram(page_q, col_q) ?
          ram_q[ram_idx(page_q, col_q)] : 8'h00;
      end
    end
  end

  assign host_dout = dout_q;

endmodule : odc_decoder

/* dv/odc_monitor.sv */
// concurrent checks on the decoder ports
`timescale 1ns/100ps
module odc_monitor
  import odc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // host side
  input wire odc_pin_type host_pins,
  input wire logic serial_mode,
  input wire logic [7:0] host_dout,
  // status and settings
  input wire logic busy,
  input wire logic wr_ready,
  input wire odc_cfg_type cfg
);
  // ========
  // helper counters
  logic [7:0] up_q;
  logic [3:0] wr_age_q;
  logic [3:0] rd_age_q;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      up_q <= 8'h00;
    else if (up_q != 8'hFF)
      up_q <= up_q + 8'h01;

  // ages saturate, so a stray late change still trips the check
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      wr_age_q <= 4'hF;
    else if (host_pins.wr)
      wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hF)
      wr_age_q <= wr_age_q + 4'h1;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      rd_age_q <= 4'hF;
    else if (host_pins.rd)
      rd_age_q <= 4'h0;
    else if (rd_age_q != 4'hF)
      rd_age_q <= rd_age_q + 4'h1;

  // ========
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_ready_mirrors_busy: assert property (wr_ready == !busy)
    else $error("wr_ready is not the inverse of busy");
  a_busy_init_hold: assert property (up_q < 8'h26 |-> busy)
    else $error("busy low too early after reset");
  a_busy_init_ends: assert property (up_q == 8'h30 |-> !busy)
    else $error("busy still high long after reset");
  a_status_byte: assert property ($rose(host_pins.rd) &&
    !host_pins.cmd_data_select |-> ##[2:5] (host_dout[6] == !cfg.disp_on
    && host_dout[5:0] == 6'h00))
    else $error("status byte wrong");
  a_cfg_needs_write: assert property (!$stable(cfg) |->
    wr_age_q < 4'h8)
    else $error("settings changed without a write");
  a_dout_needs_read: assert property (!$stable(host_dout) |->
    rd_age_q < 4'h8)
    else $error("read byte changed without a read");
  a_reset_settings: assert property (up_q < 8'h26 |->
    cfg == RST_CFG)
    else $error("settings differ from reset values");
  a_panel_on_cmd: assert property ($rose(host_pins.wr) && !busy &&
    !serial_mode && !host_pins.cmd_data_select && host_pins.din == 8'hAF
    |-> ##[2:8] cfg.disp_on)
    else $error("panel on command not applied");
  a_serial_read_zero: assert property (serial_mode &&
    $rose(host_pins.rd) && host_pins.cmd_data_select |-> ##[3:6]
    host_dout == 8'h00)
    else $error("serial data read not zero");
endmodule : odc_monitor

bind odc_decoder odc_monitor i_odc_monitor (.clk(clk), .sys_rst(sys_rst),
  .ce(ce), .host_pins(host_pins), .serial_mode(serial_mode),
  .host_dout(host_dout), .busy(busy), .wr_ready(wr_ready), .cfg(cfg));

/* dv/odc_host_model.sv */
// host model that drives the display pins
`timescale 1ns/100ps
module odc_host_model
  import odc_pkg::*;
(
  // clock
  input wire logic clk,
  // device answers
  input wire logic busy,
  input wire logic [7:0] dout,
  // pins driven
  output odc_pin_type pins
);
  initial pins = '{1'b0, 1'b0, 1'b0, 1'b0, 8'h5A};

  // ========
  // transfers, always changed 5 ns after the edge
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : step

  task automatic wr_byte(logic dcs, logic [7:0] b, logic poll);
    int n;
    n = 0;
    while (poll && busy !== 1'b0 && n < 200)
    begin
      step(1);
      n++;
    end
    pins.cmd_data_select = dcs;
    pins.din = b;
    pins.wr = 1'b1;
    // held past the sync delay so the byte is caught whole
    step(4);
    pins.wr = 1'b0;
    step(1);
    pins.din = ~b;
    step(3);
  endtask : wr_byte

  task automatic rd_byte(logic dcs, output logic [7:0] b);
    pins.cmd_data_select = dcs;
    pins.rd = 1'b1;
    step(5);
    b = dout;
    pins.rd = 1'b0;
    step(3);
  endtask : rd_byte

  // drop first, so every call gives the decoder a fresh rising edge
  task automatic frame_open;
    pins.frame = 1'b0;
    step(4);
    pins.frame = 1'b1;
    step(4);
  endtask : frame_open
endmodule : odc_host_model

/* dv/test_oled_display_command_decoder.sv */
// self-checking bench of the display command decoder
`timescale 1ns/100ps
module test_oled_display_command_decoder;
  import odc_pkg::*;
  // ========
  // signals
  logic clk;
  logic sys_rst;
  logic ce = 1'b1;
  logic serial_mode;
  odc_pin_type host_pins;
  logic [7:0] host_dout;
  logic busy;
  logic wr_ready;
  odc_cfg_type cfg;
  odc_cfg_type exp_cfg;
  logic [31:0] rnd = 32'h3BCF;
  logic [7:0] rb;
  logic [7:0] p;
  logic [7:0] ram [4];
  // listed codes only, argument bits masked
  logic [7:0] sbase [10] = '{8'h30, 8'h40, 8'hA0, 8'hA4, 8'hA6, 8'hAE,
    8'hC0, 8'hB0, 8'h00, 8'h10};
  logic [7:0] smask [10] = '{8'h03, 8'h3F, 8'h01, 8'h01, 8'h01, 8'h01,
    8'h0F, 8'h0F, 8'h0F, 8'h0F};
  logic [7:0] dop [6] = '{8'h81, 8'hA8, 8'hAD, 8'hD3, 8'hD5, 8'hD9};
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  odc_decoder i_odc_decoder (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .host_pins(host_pins), .serial_mode(serial_mode),
    .host_dout(host_dout), .busy(busy), .wr_ready(wr_ready), .cfg(cfg));
  odc_host_model i_odc_host_model (.clk(clk), .busy(busy),
    .dout(host_dout), .pins(host_pins));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard, the run needs well under 3000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  // ========
  // helpers
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk8(logic [7:0] got, logic [7:0] want, string what);
    comparisons++;
    if (got !== want)
    begin
      err_total++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask : chk8

  task automatic chk_cfg(string what);
    comparisons++;
    if (cfg !== exp_cfg)
    begin
      err_total++;
      $display("[ERR] %0t %s settings %h", $time, what, cfg);
    end
  endtask : chk_cfg

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // op is zero for a one-byte command, else the opcode owning b
  function automatic odc_cfg_type upd(odc_cfg_type c, logic [7:0] op,
    logic [7:0] b);
    odc_cfg_type n;
    n = c;
    case (op)
      8'h81: n.contrast = b;
      8'hA8: n.mux_ratio = b[5:0];
      8'hAD: n.pump_en = b[0];
      8'hD3: n.row_offset_value = b[5:0];
      8'hD5: n.osc_div = b;
      8'hD9: n.charge_period = b;
      default:
        casez (b)
          8'b0011_00??: n.pump_volt = b[1:0];
          8'b01??_????: n.start_line = b[5:0];
          8'b1010_000?: n.seg_mirror = b[0];
          8'b1010_010?: n.all_on = b[0];
          8'b1010_011?: n.inverse = b[0];
          8'b1010_111?: n.disp_on = b[0];
          8'b1100_????: n.scan_rev = b[3];
          default: ;
        endcase
    endcase
    return n;
  endfunction : upd

  task automatic cmd(logic [7:0] b);
    i_odc_host_model.wr_byte(1'b0, b, 1'b1);
    exp_cfg = upd(exp_cfg, 8'h00, b);
  endtask : cmd

  task automatic dbl(logic [7:0] op, logic [7:0] b);
    cmd(op);
    i_odc_host_model.wr_byte(1'b0, b, 1'b1);
    exp_cfg = upd(exp_cfg, op, b);
  endtask : dbl

  task automatic rst_dut(logic s);
    sys_rst = 1'b1;
    serial_mode = s;
    repeat (10) @(posedge clk);
    #5;
    sys_rst = 1'b0;
    exp_cfg = RST_CFG;
  endtask : rst_dut

  // ========
  // main sequence
  initial
  begin
    rst_dut(1'b0);
    chk8({7'h00, busy}, 8'h01, "init busy");
    i_odc_host_model.wr_byte(1'b0, 8'hAF, 1'b0);
    i_odc_host_model.rd_byte(1'b0, rb);
    chk8(rb, 8'hC0, "busy status");
    i_odc_host_model.step(30);
    chk_cfg("reset");
    i_odc_host_model.rd_byte(1'b0, rb);
    chk8(rb, 8'h40, "off status");
    cmd(8'hAF);
    i_odc_host_model.rd_byte(1'b0, rb);
    chk8(rb, 8'h00, "on status");
    // a whole strobe inside a frozen stretch must leave no trace
    ce = 1'b0;
    i_odc_host_model.wr_byte(1'b0, 8'hAE, 1'b0);
    chk_cfg("frozen");
    ce = 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      rnd = lfsr(rnd);
      cmd(sbase[i % 10] | (rnd[7:0] & smask[i % 10]));
      chk_cfg("single");
    end
    for (int i = 0; i < 12; i++)
    begin
      rnd = lfsr(rnd);
      p = (dop[i % 6] == 8'hAD) ? {7'h45, rnd[0]} : rnd[15:8];
      if (p[7:1] == 7'h57)
        p[4] = 1'b0;
      dbl(dop[i % 6], p);
      chk_cfg("dbl");
    end
    dbl(8'h81, 8'hA7);
    chk_cfg("param");
    cmd(8'hB2);
    cmd(8'h05);
    cmd(8'h11);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      ram[i] = rnd[7:0];
      i_odc_host_model.wr_byte(1'b1, ram[i], 1'b1);
    end
    cmd(8'h05);
    i_odc_host_model.rd_byte(1'b1, rb);
    for (int i = 0; i < 4; i++)
    begin
      i_odc_host_model.rd_byte(1'b1, rb);
      chk8(rb, ram[i], "data");
    end
    cmd(8'h06);
    cmd(8'hE0);
    for (int i = 0; i < 3; i++)
    begin
      i_odc_host_model.rd_byte(1'b1, rb);
      if (i > 0)
        chk8(rb, ram[1], "rmw read");
    end
    i_odc_host_model.wr_byte(1'b1, 8'h3C, 1'b1);
    cmd(8'hEE);
    i_odc_host_model.rd_byte(1'b1, rb);
    i_odc_host_model.rd_byte(1'b1, rb);
    chk8(rb, 8'h3C, "rmw end");
    rst_dut(1'b1);
    i_odc_host_model.step(45);
    i_odc_host_model.frame_open();
    cmd(8'h00);
    cmd(8'hA1);
    chk_cfg("serial");
    // frame still selects commands, so this read gives status
    i_odc_host_model.rd_byte(1'b0, rb);
    chk8(rb, 8'h40, "serial status");
    // new frame whose control byte selects data for the rest
    i_odc_host_model.frame_open();
    i_odc_host_model.wr_byte(1'b0, 8'h40, 1'b1);
    i_odc_host_model.rd_byte(1'b1, rb);
    chk8(rb, 8'h00, "serial read");
    report_and_stop();
  end
endmodule : test_oled_display_command_decoder
